// File: scr_map.svh
// Offsets, field positions and reset values of the low configuration group.
// Included by the package user; holds definitions only.
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// Register offsets on the 12-bit register port
`define SCR_OFS_INTF_A     12'h000
`define SCR_OFS_INTF_B     12'h001
`define SCR_OFS_DEV_CFG    12'h002
`define SCR_OFS_CATEGORY   12'h003
`define SCR_OFS_PART_LOW   12'h004
`define SCR_OFS_PART_HIGH  12'h005
`define SCR_OFS_GRADE_REV  12'h006
`define SCR_OFS_IRQ_EN     12'h020
`define SCR_OFS_IRQ_STAT   12'h024

// Field positions in interface_config_a
`define SCR_BIT_PRIMARY_RST 0
`define SCR_BIT_LSB_FIRST   1
`define SCR_BIT_ADDR_INC    2
`define SCR_BIT_SDO_ACTIVE  3

// Field positions in interface_config_b
`define SCR_BIT_ONE_INSTR   7
`define SCR_BIT_CS_STALL    6
`define SCR_BIT_SEC_RST_B   2
`define SCR_BIT_SEC_RST_A   1

// Field positions in interrupt_enable and the status register
`define SCR_BIT_EV_JITTER   4
`define SCR_BIT_EV_RX_READY 3
`define SCR_BIT_EV_FIFO     2

// Writable masks and reset values
`define SCR_MASK_INTF_A    8'h0F
`define SCR_MASK_INTF_B    8'hFE
`define SCR_MASK_IRQ       8'h1C
`define SCR_RST_INTF_A     8'h00
`define SCR_RST_INTF_B     8'h00
`define SCR_RST_DEV_CFG    8'h00
`define SCR_RST_IRQ_EN     8'h00
`define SCR_RST_IRQ_STAT   8'h00

`endif

// File: scr_pkg.sv
// Types shared by the configuration register group.
// Assumes nothing beyond a SystemVerilog compiler.
package scr_pkg;

  // Power state selected by the two-bit operating mode field
  typedef enum logic [1:0] {
    SCR_PWR_NORMAL  = 2'h0,
    SCR_PWR_LOW     = 2'h1,
    SCR_PWR_STANDBY = 2'h2,
    SCR_PWR_SLEEP   = 2'h3
  } scr_power_type;

  typedef logic [11:0] scr_addr_type;
  typedef logic [7:0]  scr_byte_type;

endpackage

// File: scr_config_regs.sv
// Low configuration, identification and interrupt-enable register group.
// Assumes a serial framer on clk that issues one-cycle register strobes,
// and event sources that run on the same clock.
// Operation
// - Writing 1 to the primary reset bit pulses soft reset; 0 does not.
// - Config B bit 2 written 1 pulses secondary reset 1, then self-clears.
// - Config B bit 1 written 1 pulses secondary reset 0, then self-clears.
// - Enable bit 4 gates reference jitter events onto the interrupt; reset 0.
// - Enable bit 3 lets a fall of link receiver ready raise the interrupt.
// - Enable bit 2 lets lane FIFO overflow or underflow raise the interrupt.
// - Status flags stay set until host writes 1 there or soft reset runs; writing 0 keeps them.
// - Primary reset bit clears by itself on the edge its pulse starts, reading back 0.
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_config_regs #(
  parameter logic [7:0]  PART_CATEGORY = 8'h5A,   // Arbitrary value
  parameter logic [15:0] PART_NUMBER   = 16'h1234, // Arbitrary value
  parameter logic [3:0]  PART_GRADE    = 4'h1,    // Arbitrary value
  parameter logic [3:0]  SILICON_REV   = 4'h2     // Arbitrary value
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Register port from the serial framer
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  input  wire scr_pkg::scr_addr_type  regAddr,
  input  wire scr_pkg::scr_byte_type  regWrData,
  output      scr_pkg::scr_byte_type  regRdData,
  output      logic                   regRdValid,
  // Event sources
  input  wire logic                   refJitterEvent,
  input  wire logic                   linkRxReady,
  input  wire logic                   laneFifoError,
  // Reset pulses and configuration outputs
  output      logic                   primaryResetPulse,
  output      logic                   secondaryResetPulseA,
  output      logic                   secondaryResetPulseB,
  output      logic                   lsbFirst,
  output      logic                   addrIncrement,
  output      logic                   sdoActive,
  output      logic                   oneInstructionOnly,
  output      logic                   csStallEnable,
  output      scr_pkg::scr_power_type powerStateSelect,
  output      logic                   irqOut
);

  scr_pkg::scr_byte_type  intfA, next_intfA;
  scr_pkg::scr_byte_type  intfB, next_intfB;
  scr_pkg::scr_byte_type  devCfg, next_devCfg;
  scr_pkg::scr_byte_type  irqEn, next_irqEn;
  scr_pkg::scr_byte_type  irqStat, next_irqStat;
  scr_pkg::scr_byte_type  next_regRdData;
  scr_pkg::scr_power_type next_powerStateSelect;
  logic                   next_regRdValid;
  logic                   next_primaryResetPulse;
  logic                   next_secondaryResetPulseA;
  logic                   next_secondaryResetPulseB;
  logic                   rxReadyLast;
  logic                   next_irqOut;
  scr_pkg::scr_byte_type  eventVec;

  // Address match for a write strobe
  function automatic logic wrHit(input scr_pkg::scr_addr_type ofs);
    wrHit = regWrite && (regAddr == ofs);
  endfunction

  // Configuration outputs read straight from register bits
  assign lsbFirst           = intfA[`SCR_BIT_LSB_FIRST];
  assign addrIncrement      = intfA[`SCR_BIT_ADDR_INC];
  assign sdoActive          = intfA[`SCR_BIT_SDO_ACTIVE];
  assign oneInstructionOnly = intfB[`SCR_BIT_ONE_INSTR];
  assign csStallEnable      = intfB[`SCR_BIT_CS_STALL];

  // Events placed at their status bit positions
  always_comb begin
    eventVec = 8'h00;
    eventVec[`SCR_BIT_EV_JITTER]   = refJitterEvent;
    eventVec[`SCR_BIT_EV_RX_READY] = rxReadyLast && !linkRxReady;
    eventVec[`SCR_BIT_EV_FIFO]     = laneFifoError;
  end

  // Next register values, reset pulses and read data
  always_comb begin
    next_intfA   = intfA;
    next_intfB   = intfB;
    next_devCfg  = devCfg;
    next_irqEn   = irqEn;
    next_irqStat = irqStat | (eventVec & `SCR_MASK_IRQ);
    // Each pulse follows its request bit by one cycle; the bit clears on that same edge
    next_primaryResetPulse    = intfA[`SCR_BIT_PRIMARY_RST];
    next_secondaryResetPulseA = intfB[`SCR_BIT_SEC_RST_A];
    next_secondaryResetPulseB = intfB[`SCR_BIT_SEC_RST_B];
    next_intfA[`SCR_BIT_PRIMARY_RST] = 1'b0;
    next_intfB[`SCR_BIT_SEC_RST_A]   = 1'b0;
    next_intfB[`SCR_BIT_SEC_RST_B]   = 1'b0;
    if (primaryResetPulse) begin
      // Soft reset restores configuration; a new event still sets its flag
      next_intfA   = `SCR_RST_INTF_A;
      next_intfB   = `SCR_RST_INTF_B;
      next_devCfg  = `SCR_RST_DEV_CFG;
      next_irqEn   = `SCR_RST_IRQ_EN;
      next_irqStat = `SCR_RST_IRQ_STAT | (eventVec & `SCR_MASK_IRQ);
    end else begin
      if (wrHit(`SCR_OFS_INTF_A)) begin
        next_intfA = regWrData & `SCR_MASK_INTF_A;
      end
      if (wrHit(`SCR_OFS_INTF_B)) begin
        next_intfB = regWrData & `SCR_MASK_INTF_B;
      end
      if (wrHit(`SCR_OFS_DEV_CFG)) begin
        next_devCfg = regWrData;
      end
      if (wrHit(`SCR_OFS_IRQ_EN)) begin
        next_irqEn = regWrData & `SCR_MASK_IRQ;
      end
      if (wrHit(`SCR_OFS_IRQ_STAT)) begin
        // Write one clears; a same-cycle event wins
        next_irqStat = (irqStat & ~regWrData)
                       | (eventVec & `SCR_MASK_IRQ);
      end
    end
    next_powerStateSelect = scr_pkg::scr_power_type'(next_devCfg[1:0]);
    next_irqOut = |(next_irqStat & next_irqEn);
    // Read decode; unmapped offsets read zero
    next_regRdValid = regRead;
    next_regRdData  = 8'h00;
    if (regRead) begin
      unique case (regAddr)
        `SCR_OFS_INTF_A:    next_regRdData = {intfA[0], intfA[1], intfA[2],
                                              intfA[3], intfA[3:0]};
        `SCR_OFS_INTF_B:    next_regRdData = intfB;
        `SCR_OFS_DEV_CFG:   next_regRdData = devCfg;
        `SCR_OFS_CATEGORY:  next_regRdData = PART_CATEGORY;
        `SCR_OFS_PART_LOW:  next_regRdData = PART_NUMBER[7:0];
        `SCR_OFS_PART_HIGH: next_regRdData = PART_NUMBER[15:8];
        `SCR_OFS_GRADE_REV: next_regRdData = {PART_GRADE, SILICON_REV};
        `SCR_OFS_IRQ_EN:    next_regRdData = irqEn;
        `SCR_OFS_IRQ_STAT:  next_regRdData = irqStat;
        default:            next_regRdData = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intfA                <= `SCR_RST_INTF_A;
      intfB                <= `SCR_RST_INTF_B;
      devCfg               <= `SCR_RST_DEV_CFG;
      irqEn                <= `SCR_RST_IRQ_EN;
      irqStat              <= `SCR_RST_IRQ_STAT;
      rxReadyLast          <= 1'b1;
      primaryResetPulse    <= 1'b0;
      secondaryResetPulseA <= 1'b0;
      secondaryResetPulseB <= 1'b0;
      powerStateSelect     <= scr_pkg::SCR_PWR_NORMAL;
      irqOut               <= 1'b0;
      regRdData            <= 8'h00;
      regRdValid           <= 1'b0;
    end else begin
      intfA                <= next_intfA;
      intfB                <= next_intfB;
      devCfg               <= next_devCfg;
      irqEn                <= next_irqEn;
      irqStat              <= next_irqStat;
      rxReadyLast          <= linkRxReady;
      primaryResetPulse    <= next_primaryResetPulse;
      secondaryResetPulseA <= next_secondaryResetPulseA;
      secondaryResetPulseB <= next_secondaryResetPulseB;
      powerStateSelect     <= next_powerStateSelect;
      irqOut               <= next_irqOut;
      regRdData            <= next_regRdData;
      regRdValid           <= next_regRdValid;
    end
  end

  // Checks on the register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_primary;
    wrHit(`SCR_OFS_INTF_A) && regWrData[`SCR_BIT_PRIMARY_RST]
      && !primaryResetPulse;
  endsequence

  sequence s_primary_done;
    intfA[`SCR_BIT_PRIMARY_RST] ##1 primaryResetPulse;
  endsequence

  property p_primary_pulse;
    s_wr_primary |=> s_primary_done;
  endproperty
  a_primary_pulse: assert property (p_primary_pulse)
    else $error("primary reset pulse missing");

  property p_primary_zero;
    wrHit(`SCR_OFS_INTF_A) && !regWrData[`SCR_BIT_PRIMARY_RST]
      |=> !intfA[`SCR_BIT_PRIMARY_RST] ##1 !primaryResetPulse;
  endproperty
  a_primary_zero: assert property (p_primary_zero)
    else $error("primary reset pulsed after writing zero");

  property p_primary_clear;
    intfA[`SCR_BIT_PRIMARY_RST] && !wrHit(`SCR_OFS_INTF_A)
      |=> !intfA[`SCR_BIT_PRIMARY_RST] && primaryResetPulse;
  endproperty
  a_primary_clear: assert property (p_primary_clear)
    else $error("primary reset bit did not clear");

  // No request may be pending, else back-to-back writes merge the pulses
  property p_sec_b_pulse;
    wrHit(`SCR_OFS_INTF_B) && regWrData[`SCR_BIT_SEC_RST_B]
      && !primaryResetPulse && !intfB[`SCR_BIT_SEC_RST_B]
      |=> intfB[`SCR_BIT_SEC_RST_B] ##1
          (secondaryResetPulseB && !$past(secondaryResetPulseB, 1));
  endproperty
  a_sec_b_pulse: assert property (p_sec_b_pulse)
    else $error("secondary reset 1 pulse missing");

  property p_sec_a_pulse;
    wrHit(`SCR_OFS_INTF_B) && regWrData[`SCR_BIT_SEC_RST_A]
      && !primaryResetPulse
      |=> intfB[`SCR_BIT_SEC_RST_A] ##1 secondaryResetPulseA;
  endproperty
  a_sec_a_pulse: assert property (p_sec_a_pulse)
    else $error("secondary reset 0 pulse missing");

  property p_sec_a_single;
    secondaryResetPulseA && !intfB[`SCR_BIT_SEC_RST_A]
      |=> !secondaryResetPulseA;
  endproperty
  a_sec_a_single: assert property (p_sec_a_single)
    else $error("secondary reset 0 pulse too long");

  property p_jitter_irq;
    refJitterEvent && irqEn[`SCR_BIT_EV_JITTER] && !primaryResetPulse
      && !wrHit(`SCR_OFS_IRQ_EN) |=> irqOut;
  endproperty
  a_jitter_irq: assert property (p_jitter_irq)
    else $error("enabled jitter event gave no interrupt");

  property p_irq_masked;
    (irqStat & irqEn) == 8'h00 |-> !irqOut;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised with all sources masked");

  property p_rx_ready_irq;
    $fell(linkRxReady) && irqEn[`SCR_BIT_EV_RX_READY] && !primaryResetPulse
      && !wrHit(`SCR_OFS_IRQ_EN)
      |=> irqStat[`SCR_BIT_EV_RX_READY] && irqOut;
  endproperty
  a_rx_ready_irq: assert property (p_rx_ready_irq)
    else $error("receiver ready fall gave no interrupt");

  property p_fifo_flag;
    laneFifoError && !primaryResetPulse |=> irqStat[`SCR_BIT_EV_FIFO];
  endproperty
  a_fifo_flag: assert property (p_fifo_flag)
    else $error("lane FIFO event not flagged");

  property p_flag_sticky;
    !wrHit(`SCR_OFS_IRQ_STAT) && !primaryResetPulse
      |=> (irqStat & $past(irqStat)) == $past(irqStat);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("status flag lost without a clear");

  property p_flag_clear;
    wrHit(`SCR_OFS_IRQ_STAT) && regWrData[`SCR_BIT_EV_FIFO]
      && !laneFifoError && !primaryResetPulse
      |=> !irqStat[`SCR_BIT_EV_FIFO];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("write one did not clear the flag");

  property p_power_state;
    wrHit(`SCR_OFS_DEV_CFG) && !primaryResetPulse
      |=> powerStateSelect == $past(regWrData[1:0])
          && devCfg[1:0] == powerStateSelect;
  endproperty
  a_power_state: assert property (p_power_state)
    else $error("power state does not follow the mode field");

endmodule

// File: scr_host_model.sv
// Serial host model that issues register strobes to the config group.
// Assumes the block samples strobes on the rising edge of clk.
`timescale 1ns/1ps

module scr_host_model (
  // Clock
  input  wire logic                  clk,
  // Register strobes toward the block
  output      logic                  regWrite,
  output      logic                  regRead,
  output      scr_pkg::scr_addr_type regAddr,
  output      scr_pkg::scr_byte_type regWrData
);
  // Idle bus; released data shows a changing pattern
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 12'h000;
    regWrData = 8'h00;
  end

  // One write strobe held over a single sampling edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask

  // One read strobe held over a single sampling edge
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
  endtask
endmodule

// File: scr_config_regs_tb.sv
// Self-checking bench for the configuration register group.
// Assumes the host model drives strobes; events come from this bench.
`timescale 1ns/1ps

module scr_config_regs_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrite, regRead, regRdValid;
  scr_pkg::scr_addr_type regAddr;
  scr_pkg::scr_byte_type regWrData, regRdData, rnd, en;
  logic refJitterEvent = 1'b0;
  logic linkRxReady = 1'b1;
  logic laneFifoError = 1'b0;
  logic pulseP, pulseA, pulseB, lsbFirst, addrIncrement, sdoActive;
  logic oneInstructionOnly, csStallEnable, irqOut;
  scr_pkg::scr_power_type powerStateSelect;
  int failCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  int nP = 0;
  int nA = 0;
  int nB = 0;
  scr_pkg::scr_byte_type expQ[$];

  // Clock
  always #50 clk = ~clk;

  scr_host_model u_host (.clk(clk), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData));

  scr_config_regs u_dut (.clk(clk), .sys_rst(sys_rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .refJitterEvent(refJitterEvent),
    .linkRxReady(linkRxReady), .laneFifoError(laneFifoError),
    .primaryResetPulse(pulseP), .secondaryResetPulseA(pulseA),
    .secondaryResetPulseB(pulseB), .lsbFirst(lsbFirst),
    .addrIncrement(addrIncrement), .sdoActive(sdoActive),
    .oneInstructionOnly(oneInstructionOnly),
    .csStallEnable(csStallEnable),
    .powerStateSelect(powerStateSelect), .irqOut(irqOut));

  // Compare tasks for bytes and single bits
  task automatic chkByte(input string n, input logic [7:0] e,
                         input logic [7:0] s);
    totalChecks++;
    if (s !== e) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chkBit(input string n, input logic e, input logic s);
    chkByte(n, {7'h00, e}, {7'h00, s});
  endtask

  // Note the expected byte, then issue the read
  task automatic rdx(input logic [11:0] a, input logic [7:0] e);
    expQ.push_back(e);
    u_host.rd(a);
  endtask

  // One-cycle event: 0 jitter, 1 ready fall, 2 lane FIFO
  task automatic fire(input int k);
    @(posedge clk);
    refJitterEvent <= (k == 0);
    linkRxReady <= (k != 1);
    laneFifoError <= (k == 2);
    @(posedge clk);
    refJitterEvent <= 1'b0;
    linkRxReady <= 1'b1;
    laneFifoError <= 1'b0;
    @(negedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Read monitor takes the oldest note per returned byte
  always @(posedge clk) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() > 0)
        chkByte("regRdData", expQ.pop_front(), regRdData);
      else
        chkByte("strayRead", 8'h00, 8'hFF);
    end
  end

  // Pulse counters and run ceiling
  always @(posedge clk) begin
    nP <= nP + int'(pulseP === 1'b1);
    nA <= nA + int'(pulseA === 1'b1);
    nB <= nB + int'(pulseB === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failCount++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(64));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdx(12'h001, 8'h00);
    rdx(12'h002, 8'h00);
    rdx(12'h020, 8'h00);
    rdx(12'h003, 8'h5A);
    rdx(12'h004, 8'h34);
    rdx(12'h005, 8'h12);
    rdx(12'h006, 8'h12);
    rdx(12'h7FF, 8'h00);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      rnd = (8'($urandom()) & 8'hFC) | 8'(m);
      u_host.wr(12'h002, rnd);
      @(negedge clk);
      chkByte("powerState", 8'(m), 8'(powerStateSelect));
      rdx(12'h002, rnd);
    end
    $display("test power modes done");
    u_host.wr(12'h001, 8'hC4);
    rdx(12'h001, 8'hC0);
    @(negedge clk);
    chkByte("pulseB", 8'h01, 8'(nB));
    chkBit("oneInstr", 1'b1, oneInstructionOnly);
    chkBit("csStall", 1'b1, csStallEnable);
    u_host.wr(12'h001, 8'h02);
    rdx(12'h001, 8'h00);
    @(negedge clk);
    chkByte("pulseA", 8'h01, 8'(nA));
    chkByte("pulseB", 8'h01, 8'(nB));
    $display("test secondary resets done");
    u_host.wr(12'h000, 8'h0E);
    rdx(12'h000, 8'h7E);
    @(negedge clk);
    chkBit("lsbFirst", 1'b1, lsbFirst);
    chkBit("addrInc", 1'b1, addrIncrement);
    chkBit("sdoActive", 1'b1, sdoActive);
    chkByte("pulseP", 8'h00, 8'(nP));
    u_host.wr(12'h000, 8'h01);
    rdx(12'h000, 8'h00);
    rdx(12'h002, 8'h00);
    @(negedge clk);
    chkByte("pulseP", 8'h01, 8'(nP));
    $display("test primary reset done");
    u_host.wr(12'h020, 8'hFF);
    rdx(12'h020, 8'h1C);
    for (int k = 0; k < 3; k++) begin
      en = 8'h10 >> k;
      u_host.wr(12'h020, en);
      fire(k);
      chkBit("irqOut", 1'b1, irqOut);
      u_host.wr(12'h024, ~en & 8'h1C);
      rdx(12'h024, en);
      u_host.wr(12'h024, en);
      @(negedge clk);
      chkBit("irqOut", 1'b0, irqOut);
      u_host.wr(12'h020, 8'h1C ^ en);
      fire(k);
      chkBit("irqOut", 1'b0, irqOut);
      rdx(12'h024, en);
      u_host.wr(12'h024, en);
    end
    $display("test interrupt enables done");
    repeat (3) @(posedge clk);
    chkByte("pendingReads", 8'h00, 8'(expQ.size()));
    summarize();
  end
endmodule
